// [test_transfer_decode.sv]
`timescale 1ns/1ps
module test_transfer_decode
  import tdec_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic        start,
  input  wire logic        prefixed,
  input  wire logic [7:0]  opcode,
  input  wire logic [15:0] opnd_pc,
  output logic             ready,
  output logic             done,
  output result_t          result,
  output mem_req_t         mem_req,
  input  wire logic [7:0]  mem_rdata,
  input  wire reg_req_t    reg_req,
  output logic [7:0]       reg_rdata
);

  seq_state_t  state_r;
  logic [2:0]  cnt_r;
  dec_t        dec_r;
  logic        pre_r;
  logic [7:0]  op_r;
  logic [15:0] pc_r;
  logic [7:0]  b0_r;
  logic [7:0]  b1_r;
  logic [7:0]  m_r;
  logic [7:0]  accum_r;
  logic [15:0] index_r;
  logic [15:0] stack_r;
  logic [7:0]  flags_r;
  logic        err_r;
  logic        done_r;
  result_t     result_r;
  logic [7:0]  rdata_r;

  dec_t        dec_in;
  logic        take;
  logic        finish;
  logic [7:0]  first_byte;
  logic [7:0]  second_byte;
  logic [15:0] ea;
  logic [7:0]  operand;
  logic [7:0]  test_val;
  logic        sw_wr;

  function automatic dec_t decode(input logic pre, input logic [7:0] op);
    dec_t d;
    d.mode   = illegal_mode;
    d.kind   = generic_op;
    d.nbytes = 2'd0;
    d.mem    = 1'b0;
    d.last   = 3'h0;
    if (pre)
    begin
      case (op[7:4])
        4'h6, 4'hE: d.mode = stack_short_offset_mode;
        4'hD:       d.mode = stack_long_offset_mode;
        default:    d.mode = illegal_mode;
      endcase
    end
    else
    begin
      case (op[7:4])
        4'h0:             d.mode = direct_branch_mode;
        4'h3, 4'hB:       d.mode = direct_mode;
        4'h4, 4'h5, 4'h9: d.mode = inherent_mode;
        4'h6, 4'hE:       d.mode = indexed_short_offset_mode;
        4'h7, 4'hF:       d.mode = indexed_mode;
        4'hC:             d.mode = extended_addr_mode;
        4'hD:             d.mode = indexed_long_offset_mode;
        default:          d.mode = illegal_mode;
      endcase
    end
    case (d.mode)
      direct_mode, indexed_short_offset_mode, stack_short_offset_mode:
        d.nbytes = 2'd1;
      extended_addr_mode, indexed_long_offset_mode, stack_long_offset_mode,
      direct_branch_mode:
        d.nbytes = 2'd2;
      default:
        d.nbytes = 2'd0;
    endcase
    // Forms this slice does not execute only gather their operand bytes.
    d.last = {1'b0, d.nbytes};
    if (pre && op == OPC_ZT_STACK)
    begin
      d.kind = zero_test_op;
      d.last = CYC_ZT_STACK - 3'h1;
    end
    else if (!pre)
    begin
      case (op)
        OPC_ZT_DIR, OPC_ZT_A, OPC_ZT_X, OPC_ZT_SHORT, OPC_ZT_IDX:
          d.kind = zero_test_op;
        OPC_STK_TO_IDX: d.kind = stack_to_index_op;
        OPC_IDX_TO_STK: d.kind = index_to_stack_op;
        OPC_IDX_TO_ACC: d.kind = index_to_accum_op;
        default:        d.kind = generic_op;
      endcase
      case (op)
        OPC_ZT_DIR:     d.last = CYC_ZT_DIR - 3'h1;
        OPC_ZT_A:       d.last = CYC_ZT_INH - 3'h1;
        OPC_ZT_X:       d.last = CYC_ZT_INH - 3'h1;
        OPC_ZT_SHORT:   d.last = CYC_ZT_SHORT - 3'h1;
        OPC_ZT_IDX:     d.last = CYC_ZT_IDX - 3'h1;
        OPC_STK_TO_IDX: d.last = CYC_STK_TO_IDX - 3'h1;
        OPC_IDX_TO_STK: d.last = CYC_IDX_TO_STK - 3'h1;
        OPC_IDX_TO_ACC: d.last = CYC_IDX_TO_ACC - 3'h1;
        default:        d.last = {1'b0, d.nbytes};
      endcase
    end
    // Only a zero test of a memory operand needs the extra data read.
    d.mem = (d.kind == zero_test_op) && (d.mode != inherent_mode);
    return d;
  endfunction

  assign dec_in = decode(prefixed, opcode);
  assign ready  = (state_r == st_idle);
  assign take   = ready && start;
  assign finish = (state_r == st_run) && (cnt_r == dec_r.last);
  assign sw_wr  = reg_req.wr && ready;

  // Bytes are used in the cycle they arrive so no fetch cycle is lost.
  assign first_byte  = (cnt_r == 3'h1) ? mem_rdata : b0_r;
  assign second_byte = (cnt_r == 3'h2) ? mem_rdata : b1_r;
  assign operand     = (cnt_r == {1'b0, dec_r.nbytes} + 3'h1) ?
                       mem_rdata : m_r;
  assign test_val    = (dec_r.mode != inherent_mode) ? operand :
                       (op_r == OPC_ZT_A) ? accum_r : index_r[7:0];

  ea_former u_ea_former (
    .mode        (dec_r.mode),
    .first_byte  (first_byte),
    .second_byte (second_byte),
    .index_pair  (index_r),
    .stack_ptr   (stack_r),
    .ea          (ea)
  );

  always_comb
  begin
    mem_req.rd   = 1'b0;
    mem_req.addr = 16'h0000;
    if (state_r == st_run)
    begin
      if (cnt_r < {1'b0, dec_r.nbytes})
      begin
        mem_req.rd   = 1'b1;
        mem_req.addr = pc_r + {13'h0000, cnt_r};
      end
      else if (dec_r.mem && cnt_r == {1'b0, dec_r.nbytes})
      begin
        mem_req.rd   = 1'b1;
        mem_req.addr = ea;
      end
    end
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      state_r <= st_idle;
      cnt_r   <= 3'h0;
    end
    else
    begin
      unique case (state_r)
        st_idle:
        begin
          cnt_r <= 3'h0;
          if (start)
            state_r <= st_run;
        end
        st_run:
        begin
          cnt_r <= cnt_r + 3'h1;
          if (finish)
            state_r <= st_idle;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      dec_r <= '0;
      pre_r <= 1'b0;
      op_r  <= 8'h00;
      pc_r  <= 16'h0000;
    end
    else if (take)
    begin
      dec_r <= dec_in;
      pre_r <= prefixed;
      op_r  <= opcode;
      pc_r  <= opnd_pc;
    end
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      b0_r <= 8'h00;
      b1_r <= 8'h00;
      m_r  <= 8'h00;
    end
    else if (state_r == st_run)
    begin
      if (cnt_r == 3'h1)
        b0_r <= mem_rdata;
      if (cnt_r == 3'h2)
        b1_r <= mem_rdata;
      if (cnt_r == {1'b0, dec_r.nbytes} + 3'h1)
        m_r <= mem_rdata;
    end
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      accum_r <= RST_ACCUM;
    else if (finish && dec_r.kind == index_to_accum_op)
      accum_r <= index_r[7:0];
    else if (sw_wr && reg_req.addr == REG_ACCUM)
      accum_r <= reg_req.wdata;
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      index_r <= RST_INDEX;
    else if (finish && dec_r.kind == stack_to_index_op)
      index_r <= stack_r + 16'h0001;
    else if (sw_wr && reg_req.addr == REG_IDX_LO)
      index_r[7:0] <= reg_req.wdata;
    else if (sw_wr && reg_req.addr == REG_IDX_HI)
      index_r[15:8] <= reg_req.wdata;
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      stack_r <= RST_STACK;
    else if (finish && dec_r.kind == index_to_stack_op)
      stack_r <= index_r - 16'h0001;
    else if (sw_wr && reg_req.addr == REG_SP_LO)
      stack_r[7:0] <= reg_req.wdata;
    else if (sw_wr && reg_req.addr == REG_SP_HI)
      stack_r[15:8] <= reg_req.wdata;
  end

  // A zero test moves only V, N and Z; H, I and C keep their values.
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      flags_r <= RST_FLAGS;
    else if (finish && dec_r.kind == zero_test_op)
    begin
      flags_r[FLAG_V] <= 1'b0;
      flags_r[FLAG_N] <= test_val[7];
      flags_r[FLAG_Z] <= (test_val == 8'h00);
    end
    else if (sw_wr && reg_req.addr == REG_FLAGS)
      flags_r <= reg_req.wdata | FLAGS_FIXED_ONES;
  end

  // A new illegal opcode wins over a clear written in the same cycle.
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      err_r <= 1'b0;
    else if (finish && dec_r.mode == illegal_mode)
      err_r <= 1'b1;
    else if (reg_req.wr && reg_req.addr == REG_STATUS &&
             reg_req.wdata[STAT_ERR])
      err_r <= 1'b0;
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      done_r   <= 1'b0;
      result_r <= '0;
    end
    else
    begin
      done_r <= finish;
      if (finish)
      begin
        result_r.ea      <= ea;
        result_r.rel     <= second_byte;
        result_r.next_pc <= pc_r + {14'h0000, dec_r.nbytes};
        result_r.err     <= (dec_r.mode == illegal_mode);
      end
    end
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      rdata_r <= 8'h00;
    else if (reg_req.rd)
    begin
      case (reg_req.addr)
        REG_ACCUM:  rdata_r <= accum_r;
        REG_IDX_LO: rdata_r <= index_r[7:0];
        REG_IDX_HI: rdata_r <= index_r[15:8];
        REG_SP_LO:  rdata_r <= stack_r[7:0];
        REG_SP_HI:  rdata_r <= stack_r[15:8];
        REG_FLAGS:  rdata_r <= flags_r;
        REG_STATUS: rdata_r <= {6'h00, err_r, ~ready};
        default:    rdata_r <= 8'h00;
      endcase
    end
  end

  assign done      = done_r;
  assign result    = result_r;
  assign reg_rdata = rdata_r;

endmodule

// [tdec_pkg.sv]
// How it works
// - Zero test: V cleared, N Z set, others kept.
// - Extended: two bytes, high first, full address.
// - Long indexed: two offset bytes added to index.
// - Short indexed: one unsigned byte added to index.
// - Direct branch: address byte, then branch offset byte.
// - Long stack: two offset bytes added to stack.
package tdec_pkg;

  typedef enum logic [3:0] {
    inherent_mode,
    direct_mode,
    extended_addr_mode,
    indexed_mode,
    indexed_short_offset_mode,
    indexed_long_offset_mode,
    stack_short_offset_mode,
    stack_long_offset_mode,
    direct_branch_mode,
    illegal_mode
  } addr_mode_t;

  typedef enum logic [2:0] {
    generic_op,
    zero_test_op,
    stack_to_index_op,
    index_to_stack_op,
    index_to_accum_op
  } op_kind_t;

  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_run  = 2'b01
  } seq_state_t;

  typedef struct packed {
    addr_mode_t mode;
    op_kind_t   kind;
    logic [1:0] nbytes;
    logic       mem;
    logic [2:0] last;
  } dec_t;

  typedef struct packed {
    logic        rd;
    logic [15:0] addr;
  } mem_req_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [2:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic [15:0] ea;
    logic [7:0]  rel;
    logic [15:0] next_pc;
    logic        err;
  } result_t;

  localparam logic [7:0] PREFIX_BYTE    = 8'h9E;
  localparam logic [7:0] OPC_ZT_DIR     = 8'h3D;
  localparam logic [7:0] OPC_ZT_A       = 8'h4D;
  localparam logic [7:0] OPC_ZT_X       = 8'h5D;
  localparam logic [7:0] OPC_ZT_SHORT   = 8'h6D;
  localparam logic [7:0] OPC_ZT_IDX     = 8'h7D;
  localparam logic [7:0] OPC_ZT_STACK   = 8'h6D;
  localparam logic [7:0] OPC_STK_TO_IDX = 8'h95;
  localparam logic [7:0] OPC_IDX_TO_STK = 8'h94;
  localparam logic [7:0] OPC_IDX_TO_ACC = 8'h9F;

  localparam logic [2:0] CYC_ZT_DIR     = 3'h3;
  localparam logic [2:0] CYC_ZT_INH     = 3'h1;
  localparam logic [2:0] CYC_ZT_SHORT   = 3'h3;
  localparam logic [2:0] CYC_ZT_IDX     = 3'h2;
  localparam logic [2:0] CYC_ZT_STACK   = 3'h4;
  localparam logic [2:0] CYC_STK_TO_IDX = 3'h2;
  localparam logic [2:0] CYC_IDX_TO_STK = 3'h2;
  localparam logic [2:0] CYC_IDX_TO_ACC = 3'h1;

  localparam int unsigned FLAG_V = 7;
  localparam int unsigned FLAG_H = 4;
  localparam int unsigned FLAG_I = 3;
  localparam int unsigned FLAG_N = 2;
  localparam int unsigned FLAG_Z = 1;
  localparam int unsigned FLAG_C = 0;
  localparam logic [7:0] FLAGS_FIXED_ONES = 8'h60;
  localparam int unsigned STAT_BUSY = 0;
  localparam int unsigned STAT_ERR  = 1;

  localparam logic [2:0] REG_ACCUM  = 3'h0;
  localparam logic [2:0] REG_IDX_LO = 3'h1;
  localparam logic [2:0] REG_IDX_HI = 3'h2;
  localparam logic [2:0] REG_SP_LO  = 3'h3;
  localparam logic [2:0] REG_SP_HI  = 3'h4;
  localparam logic [2:0] REG_FLAGS  = 3'h5;
  localparam logic [2:0] REG_STATUS = 3'h6;

  localparam logic [7:0]  RST_ACCUM = 8'h00;
  localparam logic [15:0] RST_INDEX = 16'h0000;
  localparam logic [15:0] RST_STACK = 16'h00FF;
  localparam logic [7:0]  RST_FLAGS = 8'h68;

endpackage

// [ea_former.sv]
`timescale 1ns/1ps
module ea_former
  import tdec_pkg::*;
(
  input  addr_mode_t  mode,
  input  logic [7:0]  first_byte,
  input  logic [7:0]  second_byte,
  input  logic [15:0] index_pair,
  input  logic [15:0] stack_ptr,
  output logic [15:0] ea
);

  logic [15:0] pair_bytes;

  // Two-byte operands always arrive high byte first.
  assign pair_bytes = {first_byte, second_byte};

  always_comb
  begin
    case (mode)
      direct_mode:               ea = {8'h00, first_byte};
      direct_branch_mode:        ea = {8'h00, first_byte};
      extended_addr_mode:        ea = pair_bytes;
      indexed_mode:              ea = index_pair;
      indexed_short_offset_mode: ea = index_pair + {8'h00, first_byte};
      indexed_long_offset_mode:  ea = index_pair + pair_bytes;
      stack_short_offset_mode:   ea = stack_ptr + {8'h00, first_byte};
      stack_long_offset_mode:    ea = stack_ptr + pair_bytes;
      default:                   ea = 16'h0000;
    endcase
  end

endmodule

// [tdec_props.sv]
`timescale 1ns/1ps
module tdec_props
  import tdec_pkg::*;
(
  input wire logic        clock,
  input wire logic        nrst,
  input wire logic        start,
  input wire logic        prefixed,
  input wire logic [7:0]  opcode,
  input wire logic [15:0] opnd_pc,
  input wire logic        ready,
  input wire logic        done,
  input wire mem_req_t    mem_req,
  input wire logic [7:0]  mem_rdata
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  logic go;
  logic pre;
  assign go  = start && ready && !prefixed;
  assign pre = start && ready && prefixed;
  sequence s_len1; !done ##1 done; endsequence
  sequence s_len2; (!done)[*2] ##1 done; endsequence
  sequence s_len3; (!done)[*3] ##1 done; endsequence
  sequence s_len4; (!done)[*4] ##1 done; endsequence
  // A swapped pair of operand fetches still reads both bytes, so the
  // addresses are tied to the order, not only to the count.
  sequence s_pair;
    mem_req.rd && mem_req.addr == $past(opnd_pc) ##1
      mem_req.rd && mem_req.addr == $past(opnd_pc, 2) + 16'h0001;
  endsequence
  chk_ztest_inh: assert property
    (go && opcode inside {8'h4D, 8'h5D} |=> s_len1)
    else $error("accumulator or index test length wrong");
  chk_ztest_ix: assert property (go && opcode == 8'h7D |=> s_len2)
    else $error("indexed test length wrong");
  chk_ztest_dir: assert property
    (go && opcode inside {8'h3D, 8'h6D} |=> s_len3)
    else $error("direct or short indexed test length wrong");
  chk_ztest_sp: assert property (pre && opcode == 8'h6D |=> s_len4)
    else $error("stack test length wrong");
  chk_xfer_len: assert property
    (go && opcode inside {8'h94, 8'h95} |=> s_len2)
    else $error("stack transfer length wrong");
  chk_copy_len: assert property
    (go && opcode == 8'h9F |=> s_len1 and !mem_req.rd)
    else $error("index to accumulator copy wrong");
  chk_ready_drop: assert property (start && ready |=> !ready)
    else $error("ready stayed high after a start");
  chk_dir_fetch: assert property (go && opcode == 8'h3D |=>
    mem_req.rd && mem_req.addr == $past(opnd_pc) ##1
    mem_req.rd && mem_req.addr == {8'h00, mem_rdata})
    else $error("direct test fetch wrong");
  chk_abs_order: assert property (go && opcode == 8'hC7 |=> s_pair)
    else $error("extended operand order wrong");
  chk_long_ix: assert property (go && opcode == 8'hD7 |=> s_pair)
    else $error("long indexed operand order wrong");
  chk_long_sp: assert property (pre && opcode == 8'hD7 |=> s_pair)
    else $error("long stack operand order wrong");
  chk_dir_branch: assert property (go && opcode == 8'h01 |=> s_pair)
    else $error("direct branch operand order wrong");
endmodule

bind test_transfer_decode tdec_props chk (
  .clock(clock),
  .nrst(nrst),
  .start(start),
  .prefixed(prefixed),
  .opcode(opcode),
  .opnd_pc(opnd_pc),
  .ready(ready),
  .done(done),
  .mem_req(mem_req),
  .mem_rdata(mem_rdata)
);

// [cpu_test_transfer_decode_bench.sv]
`timescale 1ns/1ps
module cpu_test_transfer_decode_bench;
  import tdec_pkg::*;
  logic        clock;
  logic        nrst;
  logic        start;
  logic        prefixed;
  logic [7:0]  opcode;
  logic [15:0] opnd_pc;
  logic        ready;
  logic        done;
  result_t     result;
  mem_req_t    mem_req;
  logic [7:0]  mem_rdata = 8'h00;
  reg_req_t    reg_req;
  logic [7:0]  reg_rdata;
  int          fails;
  int          tests_run;
  int          i;
  int          k;
  logic [31:0] seed;
  logic [15:0] hx, sp, pc, ea, w;
  logic [7:0]  a, f, v, fl, d, d2;
  logic [7:0]  rst_exp [8];
  logic [7:0]  t_op [6] = '{8'h4D, 8'h5D, 8'h3D, 8'h6D, 8'h7D, 8'h6D};
  logic [15:0] t_cyc [6] = '{16'h1, 16'h1, 16'h3, 16'h3, 16'h2, 16'h4};
  logic [7:0]  m_op [4] = '{8'hC7, 8'hD7, 8'hD7, 8'h01};

  test_transfer_decode dut (
    .clock(clock),
    .nrst(nrst),
    .start(start),
    .prefixed(prefixed),
    .opcode(opcode),
    .opnd_pc(opnd_pc),
    .ready(ready),
    .done(done),
    .result(result),
    .mem_req(mem_req),
    .mem_rdata(mem_rdata),
    .reg_req(reg_req),
    .reg_rdata(reg_rdata)
  );

  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  // Unrequested cycles show the inverse, so a read taken a cycle late fails.
  always @(posedge clock)
    mem_rdata <= mem_req.rd ? memf(mem_req.addr) : ~mem_rdata;

  function automatic logic [7:0] memf(input logic [15:0] ad);
    return ad[7:0] ^ {ad[11:8], ad[15:12]} ^ 8'hA5;
  endfunction

  function automatic logic [31:0] nxt(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  function automatic logic [7:0] exp_flags(input logic [7:0] fo,
                                           input logic [7:0] vl);
    return (fo | 8'h60) & 8'h79 | {5'h00, vl[7], vl == 8'h00, 1'b0};
  endfunction

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected at %0t: byte %h want %h", $time, got, exp);
    end
  endtask

  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected at %0t: word %h want %h", $time, got, exp);
    end
  endtask

  task automatic wreg(input logic [2:0] ad, input logic [7:0] dat);
    @(posedge clock);
    reg_req <= '{1'b1, 1'b0, ad, dat};
    @(posedge clock);
    reg_req <= '0;
  endtask

  task automatic rreg(input logic [2:0] ad, output logic [7:0] dat);
    @(posedge clock);
    reg_req <= '{1'b0, 1'b1, ad, 8'h00};
    @(posedge clock);
    reg_req <= '0;
    #1;
    dat = reg_rdata;
  endtask

  task automatic run(input logic pf, input logic [7:0] oc,
                     input logic [15:0] n);
    logic [15:0] c;
    c = 16'h0000;
    @(posedge clock);
    start    <= 1'b1;
    prefixed <= pf;
    opcode   <= oc;
    opnd_pc  <= pc;
    @(posedge clock);
    start <= 1'b0;
    do
    begin
      @(posedge clock);
      #1;
      c = c + 16'h0001;
    end
    while (done !== 1'b1 && c < 16'h0010);
    chk_word(c, n);
  endtask

  task automatic wrap_up;
    $display("tests_run=%0d fails=%0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clock);
    fails++;
    wrap_up;
  end

  initial
  begin
    nrst = 1'b0;
    start = 1'b0;
    prefixed = 1'b0;
    opcode = 8'h00;
    opnd_pc = 16'h0000;
    reg_req = '0;
    fails = 0;
    tests_run = 0;
    seed = 32'h00002916;
    rst_exp = '{8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h68, 8'h00, 8'h00};
    repeat (10) @(posedge clock);
    nrst <= 1'b1;
    for (i = 0; i < 8; i++)
    begin
      rreg(i[2:0], d);
      chk_byte(d, rst_exp[i]);
    end
    for (i = 0; i < 24; i++)
    begin
      seed = nxt(seed);
      k = i % 6;
      a = i == 0 ? 8'h00 : seed[7:0];
      hx = i == 1 ? 16'h0080 : seed[23:8];
      sp = seed[31:16];
      pc = seed[15:0] ^ 16'h5A3C;
      f = seed[31:24];
      wreg(REG_ACCUM, a);
      wreg(REG_IDX_LO, hx[7:0]);
      wreg(REG_IDX_HI, hx[15:8]);
      wreg(REG_SP_LO, sp[7:0]);
      wreg(REG_SP_HI, sp[15:8]);
      wreg(REG_FLAGS, f);
      ea = k == 2 ? {8'h00, memf(pc)} : k == 3 ? hx + memf(pc) :
           k == 4 ? hx : sp + memf(pc);
      v = k == 0 ? a : k == 1 ? hx[7:0] : memf(ea);
      run(k == 5, t_op[k], t_cyc[k]);
      if (k > 1)
        chk_word(result.ea, ea);
      w = (k == 4 || k < 2) ? 16'h0000 : 16'h0001;
      chk_word(result.next_pc, pc + w);
      rreg(REG_FLAGS, d);
      chk_byte(d, exp_flags(f, v));
    end
    for (i = 0; i < 4; i++)
    begin
      pc = pc + 16'h0101;
      w = {memf(pc), memf(pc + 16'h0001)};
      ea = i == 0 ? w : i == 1 ? hx + w : i == 2 ? sp + w : {8'h00, w[15:8]};
      run(i == 2, m_op[i], 16'h0003);
      chk_word(result.ea, ea);
      chk_word(result.next_pc, pc + 16'h0002);
    end
    chk_byte(result.rel, w[7:0]);
    chk_byte({7'h00, result.err}, 8'h00);
    wreg(REG_SP_LO, 8'hFF);
    wreg(REG_SP_HI, 8'hFF);
    rreg(REG_FLAGS, fl);
    run(1'b0, OPC_STK_TO_IDX, 16'h0002);
    rreg(REG_IDX_LO, d);
    rreg(REG_IDX_HI, d2);
    chk_word({d2, d}, 16'h0000);
    hx = seed[15:0];
    wreg(REG_IDX_LO, hx[7:0]);
    wreg(REG_IDX_HI, hx[15:8]);
    run(1'b0, OPC_IDX_TO_STK, 16'h0002);
    rreg(REG_SP_LO, d);
    rreg(REG_SP_HI, d2);
    chk_word({d2, d}, hx - 16'h0001);
    run(1'b0, OPC_IDX_TO_ACC, 16'h0001);
    rreg(REG_ACCUM, d);
    chk_byte(d, hx[7:0]);
    rreg(REG_FLAGS, d);
    chk_byte(d, fl);
    // An undecodable opcode ends at once and raises the sticky error bit.
    run(1'b0, 8'h20, 16'h0001);
    chk_byte({7'h00, result.err}, 8'h01);
    rreg(REG_STATUS, d);
    chk_byte(d, 8'h02);
    wreg(REG_STATUS, 8'h02);
    rreg(REG_STATUS, d);
    chk_byte(d, 8'h00);
    wrap_up;
  end
endmodule
